//--- hw/usc_status_ctrl.sv
// Function
// - rx done flag tracks unread buffer, flush clears
// - tx done set at frame end with buffer empty, cleared
// - buffer empty flag, reset one, cleared by write
// - start flag on standby falling edge, write-one clear
// - sync error flag, write-one clears to idle
// - break of eleven low bits then valid sync sets flag
// - wait command takes next low-high as break
// - three vectors follow flag and enable
// - start flag interrupt on receive vector
// - sync error interrupt on receive vector
// - loopback joins transmit to receive
// - decode rs485 field, external or internal driver
// - receiver enable, clearing flushes and resets autobaud
// - transmitter release waits until data drained
// - start detector wakes from idle or standby
// - open drain pulls low only
// - double speed divides by eight, async only
// - generic autobaud takes any valid baud
// - lin autobaud checks 16 plus minus 3, 0x55
// - address filter drops non-address frames
// - decode link mode field
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module usc_status_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [usc_pkg::USC_ADR_W-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    input wire logic rxd_pin,
    output logic txd_out,
    output logic txd_oe,
    output logic line_driver_enable_pin,
    input wire logic [1:0] link_mode,
    input wire logic sleep_idle,
    input wire logic sleep_standby,
    output logic wake_req,
    input wire logic sample_tick,
    output logic rx_line,
    output logic rx_enable,
    output logic rx_flush,
    input wire logic rx_frame_stb,
    input wire usc_pkg::usc_rx_frame_s rx_frame,
    input wire logic tx_bit,
    input wire logic tx_shift_busy,
    input wire logic tx_frame_end,
    output logic tx_load,
    output logic [7:0] tx_data,
    input wire logic sync_stb,
    input wire logic [7:0] sync_byte,
    input wire logic sync_baud_ok,
    input wire logic [7:0] sync_pair_min,
    input wire logic [7:0] sync_pair_max,
    output logic autobaud_reset,
    input wire logic tx_done_vector_ack,
    output logic receive_vector,
    output logic tx_done_vector,
    output logic tx_empty_vector
);
    import usc_pkg::*;

    function automatic logic usc_hit(input logic [USC_ADR_W-1:0] a, input int idx);
        usc_hit = (a == USC_ADR_W'(idx * 4));
    endfunction : usc_hit

    usc_ctrl_a_s ctrl_a_r;
    usc_ctrl_b_s ctrl_b_r;
    usc_brk_e brk_r;
    usc_rx_frame_s rx_mem [USC_RXBUF_DEPTH];
    logic ack_r;
    logic [31:0] dat_r;
    logic tx_done_r, rxs_r, isf_r, brk_seen_r, brk_wait_r, ovf_r;
    logic tx_full_r, tx_active_r, tx_load_r;
    logic [7:0] tx_data_r;
    logic rx_wp_r, rx_rp_r;
    logic [1:0] rx_cnt_r;
    logic [2:0] rxd_s_r;
    logic rx_filt_r, rx_line_r, rx_prev_r;
    logic [3:0] samp_r, low_bits_r;
    logic rx_flush_r, ab_rst_r, wake_r, txd_r, txd_oe_r, drv_en_r;
    logic req, wr, rd, rx_fall, autobaud, lin, is_sync, mspi, bit_tick;
    logic rx_push, rx_pop, rx_done, tx_empty, sync_bad, isf_set, brk_seen_set, receiver_on_fall, isf_clr;
    logic [3:0] div_last;
    usc_rx_frame_s head;

    assign req = wb_cyc & wb_stb & ~ack_r;
    assign wr = req & wb_we & wb_sel[0];
    assign rd = req & ~wb_we;
    assign wb_ack = ack_r;
    assign wb_dat_r = dat_r;
    // link mode decode: sync and master spi are clocked modes
    assign mspi = (link_mode == USC_LINK_MSPI);
    assign is_sync = (link_mode == USC_LINK_SYNC) | mspi;
    assign autobaud = (ctrl_b_r.receive_speed_select == USC_RXM_GEN_AB) | lin;
    assign lin = (ctrl_b_r.receive_speed_select == USC_RXM_LIN_AB);
    assign receiver_on_fall = wr & usc_hit(wb_adr, USC_IDX_CTL_B) & ctrl_b_r.receiver_on & ~wb_dat_w[7];
    assign isf_clr = wr & usc_hit(wb_adr, USC_IDX_STATUS) & wb_dat_w[USC_ST_ISF];
    assign rx_done = (rx_cnt_r != 2'd0);
    assign tx_empty = ~tx_full_r;
    assign head = rx_mem[rx_rp_r];
    assign rx_fall = rx_prev_r & ~rx_line_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= req;
            if (rd) begin
                dat_r <= 32'h0000_0000;
                if (usc_hit(wb_adr, USC_IDX_STATUS)) begin
                    // command bit always reads zero
                    dat_r[7:0] <= {rx_done, tx_done_r, tx_empty, rxs_r & ctrl_b_r.start_detect_en, isf_r, 1'b0,
                        brk_seen_r, 1'b0};
                end else if (usc_hit(wb_adr, USC_IDX_CTL_A)) begin
                    dat_r[7:0] <= ctrl_a_r;
                end else if (usc_hit(wb_adr, USC_IDX_CTL_B)) begin
                    dat_r[7:0] <= ctrl_b_r;
                end else if (usc_hit(wb_adr, USC_IDX_RXDL)) begin
                    dat_r[7:0] <= rx_done ? head.data[7:0] : 8'h00;
                end else if (usc_hit(wb_adr, USC_IDX_RXDH)) begin
                    dat_r[7:0] <= rx_done ? {rx_done, ovf_r, 3'b000, head.frame_err, head.parity_err, head.data[8]}
                        : 8'h00;
                end else if (usc_hit(wb_adr, USC_IDX_TXDL)) begin
                    dat_r[7:0] <= tx_data_r;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_a_r <= usc_ctrl_a_s'(USC_CTL_A_RST);
            ctrl_b_r <= usc_ctrl_b_s'(USC_CTL_B_RST);
        end else begin
            if (wr && usc_hit(wb_adr, USC_IDX_CTL_A)) begin
                ctrl_a_r <= usc_ctrl_a_s'(wb_dat_w[7:0]);
            end
            if (wr && usc_hit(wb_adr, USC_IDX_CTL_B)) begin
                ctrl_b_r <= usc_ctrl_b_s'({wb_dat_w[7:6], 1'b0, wb_dat_w[4:0]});
            end
        end
    end

    // pin input: three stages, change accepted when last two agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxd_s_r <= 3'b111;
            rx_filt_r <= 1'b1;
            rx_line_r <= 1'b1;
            rx_prev_r <= 1'b1;
        end else begin
            rxd_s_r <= {rxd_s_r[1:0], rxd_pin};
            if (rxd_s_r[1] == rxd_s_r[2]) begin
                rx_filt_r <= rxd_s_r[2];
            end
            rx_line_r <= ctrl_a_r.loopback_en ? tx_bit : rx_filt_r;
            rx_prev_r <= rx_line_r;
        end
    end
    assign rx_line = rx_line_r;

    // bit timing for the break detector
    assign div_last = (ctrl_b_r.receive_speed_select == USC_RXM_DOUBLE && !is_sync)
        ? 4'(USC_SAMP_DOUBLE - 1) : 4'(USC_SAMP_NORMAL - 1);
    assign bit_tick = sample_tick & (samp_r >= div_last);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            samp_r <= 4'h0;
        end else if (rx_fall || bit_tick) begin
            samp_r <= 4'h0;
        end else if (sample_tick) begin
            samp_r <= samp_r + 4'h1;
        end
    end

    // sync field check: generic needs a valid baud, lin also the pattern and pair timing
    assign sync_bad = ~sync_baud_ok | (lin & ((sync_byte != USC_SYNC_CHAR)
        | (sync_pair_min < 8'(USC_LIN_PAIR_NOM - USC_LIN_PAIR_TOL))
        | (sync_pair_max > 8'(USC_LIN_PAIR_NOM + USC_LIN_PAIR_TOL))));
    assign isf_set = autobaud & (brk_r == USC_BRK_SYNC) & sync_stb & sync_bad;
    assign brk_seen_set = autobaud & (brk_r == USC_BRK_SYNC) & sync_stb & ~sync_bad;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            brk_r <= USC_BRK_IDLE;
            low_bits_r <= 4'h0;
        end else if (!ctrl_b_r.receiver_on || !autobaud || isf_clr) begin
            brk_r <= USC_BRK_IDLE;
            low_bits_r <= 4'h0;
        end else begin
            unique case (brk_r)
                USC_BRK_IDLE: begin
                    low_bits_r <= 4'h0;
                    if (!rx_line_r) begin
                        brk_r <= USC_BRK_LOW;
                    end
                end
                USC_BRK_LOW: begin
                    if (bit_tick && low_bits_r < 4'(USC_BREAK_BITS)) begin
                        low_bits_r <= low_bits_r + 4'h1;
                    end
                    if (rx_line_r) begin
                        // an armed wait accepts any width
                        brk_r <= (low_bits_r >= 4'(USC_BREAK_BITS) || brk_wait_r)
                            ? USC_BRK_SYNC : USC_BRK_IDLE;
                    end
                end
                USC_BRK_SYNC: begin
                    if (sync_stb) begin
                        brk_r <= USC_BRK_IDLE;
                    end
                end
                default: brk_r <= USC_BRK_IDLE;
            endcase
        end
    end

    // status flags: hardware set wins over a same-cycle clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_done_r <= 1'b0;
            rxs_r <= 1'b0;
            isf_r <= 1'b0;
            brk_seen_r <= 1'b0;
            brk_wait_r <= 1'b0;
        end else begin
            if (tx_frame_end && !tx_full_r) begin
                tx_done_r <= 1'b1;
            end else if (tx_done_vector_ack
                || (wr && usc_hit(wb_adr, USC_IDX_STATUS) && wb_dat_w[USC_ST_TX_DONE])) begin
                tx_done_r <= 1'b0;
            end
            if (ctrl_b_r.start_detect_en && sleep_standby && rx_fall && !mspi) begin
                rxs_r <= 1'b1;
            end else if (wr && usc_hit(wb_adr, USC_IDX_STATUS) && wb_dat_w[USC_ST_RXS]) begin
                rxs_r <= 1'b0;
            end
            if (isf_set) begin
                isf_r <= 1'b1;
            end else if (isf_clr) begin
                isf_r <= 1'b0;
            end
            if (brk_seen_set) begin
                brk_seen_r <= 1'b1;
            end else if (rx_push || !autobaud || (wr && usc_hit(wb_adr, USC_IDX_STATUS) && wb_dat_w[USC_ST_BRK])) begin
                brk_seen_r <= 1'b0;
            end
            if (wr && usc_hit(wb_adr, USC_IDX_STATUS) && wb_dat_w[USC_ST_WAIT]) begin
                brk_wait_r <= 1'b1;
            end else if (brk_r == USC_BRK_LOW && rx_line_r) begin
                brk_wait_r <= 1'b0;
            end
        end
    end

    // receive buffer, two frames deep
    assign rx_push = rx_frame_stb & ctrl_b_r.receiver_on & rx_cnt_r != 2'(USC_RXBUF_DEPTH)
        & ~(ctrl_b_r.address_only_filter & ~rx_frame.addr);
    assign rx_pop = rd & usc_hit(wb_adr, USC_IDX_RXDL) & rx_done;
    always_ff @(posedge clk) begin
        if (rx_push) begin
            rx_mem[rx_wp_r] <= rx_frame;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_wp_r <= 1'b0;
            rx_rp_r <= 1'b0;
            rx_cnt_r <= 2'd0;
            ovf_r <= 1'b0;
        end else if (!ctrl_b_r.receiver_on) begin
            rx_wp_r <= 1'b0;
            rx_rp_r <= 1'b0;
            rx_cnt_r <= 2'd0;
            ovf_r <= 1'b0;
        end else begin
            if (rx_push) begin
                rx_wp_r <= ~rx_wp_r;
            end
            if (rx_pop) begin
                rx_rp_r <= ~rx_rp_r;
            end
            rx_cnt_r <= rx_cnt_r + 2'(rx_push) - 2'(rx_pop);
            if (rx_frame_stb && rx_cnt_r == 2'(USC_RXBUF_DEPTH) && !mspi) begin
                ovf_r <= 1'b1;
            end else if (rx_pop) begin
                ovf_r <= 1'b0;
            end
        end
    end

    // transmit buffer and enable handover
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_full_r <= 1'b0;
            tx_data_r <= 8'h00;
            tx_load_r <= 1'b0;
            tx_active_r <= 1'b0;
        end else begin
            tx_load_r <= 1'b0;
            if (wr && usc_hit(wb_adr, USC_IDX_TXDL) && tx_empty) begin
                tx_full_r <= 1'b1;
                tx_data_r <= wb_dat_w[7:0];
            end else if (tx_full_r && tx_active_r && !tx_shift_busy && !tx_load_r) begin
                tx_full_r <= 1'b0;
                tx_load_r <= 1'b1;
            end
            if (ctrl_b_r.transmitter_on) begin
                tx_active_r <= 1'b1;
            end else if (!tx_full_r && !tx_shift_busy && !tx_load_r) begin
                tx_active_r <= 1'b0;
            end
        end
    end
    assign tx_load = tx_load_r;
    assign tx_data = tx_data_r;

    // pin drive: open drain only pulls low, rs485 internal drives only while busy
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txd_r <= 1'b1;
            txd_oe_r <= 1'b0;
            drv_en_r <= 1'b0;
        end else begin
            txd_r <= ctrl_b_r.open_drain_en ? 1'b0 : tx_bit;
            txd_oe_r <= tx_active_r
                & ~(ctrl_b_r.open_drain_en & tx_bit)
                & ~(ctrl_a_r.rs485_mode == USC_RS485_INT & ~tx_shift_busy);
            drv_en_r <= (ctrl_a_r.rs485_mode == USC_RS485_EXT) & tx_shift_busy;
        end
    end
    assign txd_out = txd_r;
    assign txd_oe = txd_oe_r;
    assign line_driver_enable_pin = drv_en_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_flush_r <= 1'b0;
            ab_rst_r <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            rx_flush_r <= receiver_on_fall;
            ab_rst_r <= (receiver_on_fall & autobaud) | isf_clr;
            wake_r <= ctrl_b_r.start_detect_en & (sleep_idle | sleep_standby) & rx_fall;
        end
    end
    assign rx_flush = rx_flush_r;
    assign autobaud_reset = ab_rst_r;
    assign wake_req = wake_r;
    assign rx_enable = ctrl_b_r.receiver_on;

    assign receive_vector = (rx_done & ctrl_a_r.rx_done_irq_en)
        | (rxs_r & ctrl_b_r.start_detect_en & ctrl_a_r.start_irq_en)
        | (isf_r & ctrl_a_r.autobaud_err_irq_en);
    assign tx_done_vector = tx_done_r & ctrl_a_r.tx_done_irq_en;
    assign tx_empty_vector = tx_empty & ctrl_a_r.tx_empty_irq_en;

    property p_dre_clear;
        @(posedge clk) disable iff (!rst_n)
        (wr && usc_hit(wb_adr, USC_IDX_TXDL) && tx_empty) |=> !tx_empty_vector ##0 tx_full_r;
    endproperty
    a_dre_clear: assert property (p_dre_clear) else $error("empty flag not cleared by data write");
    property p_flush;
        @(posedge clk) disable iff (!rst_n)
        receiver_on_fall |=> rx_flush ##1 !rx_done;
    endproperty
    a_flush: assert property (p_flush) else $error("receiver disable did not flush");
    property p_txc;
        @(posedge clk) disable iff (!rst_n)
        (tx_frame_end && !tx_full_r && ctrl_a_r.tx_done_irq_en && !wr) |=> tx_done_vector;
    endproperty
    a_txc: assert property (p_txc) else $error("transmit complete not raised");
    property p_wait_read;
        @(posedge clk) disable iff (!rst_n)
        (rd && usc_hit(wb_adr, USC_IDX_STATUS)) |=> wb_ack && !wb_dat_r[USC_ST_WAIT];
    endproperty
    a_wait_read: assert property (p_wait_read) else $error("wait command bit read nonzero");
    property p_loop;
        @(posedge clk) disable iff (!rst_n)
        ctrl_a_r.loopback_en |=> rx_line == $past(tx_bit);
    endproperty
    a_loop: assert property (p_loop) else $error("loopback path broken");
    property p_odrain;
        @(posedge clk) disable iff (!rst_n)
        $past(ctrl_b_r.open_drain_en) && txd_oe |-> !txd_out;
    endproperty
    a_odrain: assert property (p_odrain) else $error("open drain drove high");
    property p_filter;
        @(posedge clk) disable iff (!rst_n)
        (rx_frame_stb && ctrl_b_r.address_only_filter && !rx_frame.addr && !rx_pop) |=> $stable(rx_cnt_r);
    endproperty
    a_filter: assert property (p_filter) else $error("non-address frame kept");
    property p_lin_bad;
        @(posedge clk) disable iff (!rst_n)
        (lin && brk_r == USC_BRK_SYNC && sync_stb && sync_byte != USC_SYNC_CHAR && ctrl_b_r.receiver_on && !isf_clr)
            |=> isf_r ##0 brk_r == USC_BRK_IDLE;
    endproperty
    a_lin_bad: assert property (p_lin_bad) else $error("bad sync not flagged");
    property p_transmitter_on_hold;
        @(posedge clk) disable iff (!rst_n)
        (tx_active_r && tx_shift_busy) |=> tx_active_r;
    endproperty
    a_transmitter_on_hold: assert property (p_transmitter_on_hold) else $error("transmitter released while busy");
    property p_te;
        @(posedge clk) disable iff (!rst_n)
        (ctrl_a_r.rs485_mode == USC_RS485_EXT && tx_shift_busy) |=> line_driver_enable_pin;
    endproperty
    a_te: assert property (p_te) else $error("external driver enable missing");
endmodule : usc_status_ctrl
`default_nettype wire

//--- hw/usc_pkg.sv
package usc_pkg;
    // register indexes; byte address is four times the index
    localparam int USC_IDX_RXDL = 0;
    localparam int USC_IDX_RXDH = 1;
    localparam int USC_IDX_TXDL = 2;
    localparam int USC_IDX_STATUS = 4;
    localparam int USC_IDX_CTL_A = 5;
    localparam int USC_IDX_CTL_B = 6;
    localparam int USC_ADR_W = 8;
    // status bit positions
    localparam int USC_ST_RX_DONE = 7;
    localparam int USC_ST_TX_DONE = 6;
    localparam int USC_ST_TX_EMPTY = 5;
    localparam int USC_ST_RXS = 4;
    localparam int USC_ST_ISF = 3;
    localparam int USC_ST_BRK = 1;
    localparam int USC_ST_WAIT = 0;
    localparam logic [7:0] USC_CTL_A_RST = 8'h00;
    localparam logic [7:0] USC_CTL_B_RST = 8'h00;
    localparam logic [1:0] USC_RXM_NORMAL = 2'h0;
    localparam logic [1:0] USC_RXM_DOUBLE = 2'h1;
    localparam logic [1:0] USC_RXM_GEN_AB = 2'h2;
    localparam logic [1:0] USC_RXM_LIN_AB = 2'h3;
    localparam logic [1:0] USC_LINK_ASYNC = 2'h0;
    localparam logic [1:0] USC_LINK_SYNC = 2'h1;
    localparam logic [1:0] USC_LINK_INFRA = 2'h2;
    localparam logic [1:0] USC_LINK_MSPI = 2'h3;
    localparam logic [1:0] USC_RS485_OFF = 2'h0;
    localparam logic [1:0] USC_RS485_EXT = 2'h1;
    localparam logic [1:0] USC_RS485_INT = 2'h2;
    localparam int USC_BREAK_BITS = 11;
    localparam int USC_SAMP_NORMAL = 16;
    localparam int USC_SAMP_DOUBLE = 8;
    localparam int USC_LIN_PAIR_NOM = 16;
    localparam int USC_LIN_PAIR_TOL = 3;
    localparam logic [7:0] USC_SYNC_CHAR = 8'h55;
    localparam int USC_RXBUF_DEPTH = 2;

    typedef enum logic [1:0] {
        USC_BRK_IDLE = 2'b00,
        USC_BRK_LOW = 2'b01,
        USC_BRK_SYNC = 2'b10
    } usc_brk_e;

    typedef struct packed {
        logic addr;
        logic frame_err;
        logic parity_err;
        logic [8:0] data;
    } usc_rx_frame_s;

    typedef struct packed {
        logic rx_done_irq_en;
        logic tx_done_irq_en;
        logic tx_empty_irq_en;
        logic start_irq_en;
        logic loopback_en;
        logic autobaud_err_irq_en;
        logic [1:0] rs485_mode;
    } usc_ctrl_a_s;

    typedef struct packed {
        logic receiver_on;
        logic transmitter_on;
        logic rsvd;
        logic start_detect_en;
        logic open_drain_en;
        logic [1:0] receive_speed_select;
        logic address_only_filter;
    } usc_ctrl_b_s;
endpackage : usc_pkg

//--- test/usc_remote_node.sv
`timescale 1ns/1ps
`default_nettype none
module usc_remote_node (
    input wire logic clk,
    input wire logic txd_out,
    input wire logic txd_oe,
    output logic rxd_pin,
    output logic line_level
);
    // pull-up holds the wire high when released
    assign line_level = txd_oe ? txd_out : 1'b1;
    initial rxd_pin = 1'b1;
    task automatic send_low(input int n);
        repeat (n) @(posedge clk) rxd_pin <= 1'b0;
        @(posedge clk) rxd_pin <= 1'b1;
    endtask : send_low
endmodule : usc_remote_node
`default_nettype wire

//--- test/usart_status_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module usart_status_control_test;
    import usc_pkg::*;
    logic clk, rst_n, wb_cyc, wb_stb, wb_we, wb_ack, rxd_pin, txd_out, txd_oe, line_driver_enable_pin;
    logic [7:0] wb_adr, tx_data, sync_byte, sync_pair_min, sync_pair_max, r;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r;
    logic [1:0] link_mode;
    logic woke;
    logic sleep_idle, sleep_standby, wake_req, sample_tick, rx_line, rx_enable, rx_flush, rx_frame_stb;
    logic tx_bit, tx_shift_busy, tx_frame_end, tx_load, sync_stb, sync_baud_ok, autobaud_reset;
    logic tx_done_vector_ack, receive_vector, tx_done_vector, tx_empty_vector, line_level;
    usc_rx_frame_s rx_frame;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] q[$];
    usc_status_ctrl usc_status_ctrl_i (.clk, .rst_n, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w,
        .wb_dat_r, .wb_ack, .rxd_pin, .txd_out, .txd_oe, .line_driver_enable_pin, .link_mode, .sleep_idle,
        .sleep_standby, .wake_req, .sample_tick, .rx_line, .rx_enable, .rx_flush, .rx_frame_stb, .rx_frame,
        .tx_bit, .tx_shift_busy, .tx_frame_end, .tx_load, .tx_data, .sync_stb, .sync_byte, .sync_baud_ok,
        .sync_pair_min, .sync_pair_max, .autobaud_reset, .tx_done_vector_ack, .receive_vector,
        .tx_done_vector, .tx_empty_vector);
    usc_remote_node usc_remote_node_i (.clk, .txd_out, .txd_oe, .rxd_pin, .line_level);
    always #2 clk = ~clk;
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        $display("mismatches %0d checks_done %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    task automatic bus(input logic w, input int idx, input logic [7:0] d);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= 8'(idx * 4);
        wb_dat_w <= {24'h0000_00, d};
        do @(posedge clk); while (wb_ack !== 1'b1);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic rd(input int idx, input logic [7:0] exp);
        q.push_back(exp);
        bus(1'b0, idx, 8'h00);
    endtask : rd
    // 0 frame strobe, 1 frame end, 2 vector ack, 3 sync strobe
    task automatic pulse(input int w);
        {sync_stb, tx_done_vector_ack, tx_frame_end, rx_frame_stb} <= 4'(1 << w);
        @(posedge clk) {sync_stb, tx_done_vector_ack, tx_frame_end, rx_frame_stb} <= 4'h0;
        repeat (2) @(posedge clk);
    endtask : pulse
    // read results are compared in order as the answers come back
    always @(posedge clk) begin
        cycles++;
        if (wb_ack === 1'b1 && wb_we === 1'b0) check("read data", wb_dat_r[7:0], q.pop_front());
        sample_tick <= 1'($urandom);
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        {clk, rst_n, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w, link_mode, sleep_idle, sleep_standby} = '0;
        {sample_tick, rx_frame_stb, rx_frame, tx_bit, tx_shift_busy, tx_frame_end, sync_stb} = '0;
        {sync_byte, sync_baud_ok, tx_done_vector_ack} = '0;
        wb_sel = 4'h1;
        sync_pair_min = 8'd16;
        sync_pair_max = 8'd16;
        r = 8'($urandom(32'hab7c_a7db));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(USC_IDX_STATUS, 8'h20);
        rd(USC_IDX_CTL_A, USC_CTL_A_RST);
        rd(USC_IDX_CTL_B, USC_CTL_B_RST);
        rd(3, 8'h00);
        r = 8'($urandom);
        bus(1'b1, USC_IDX_CTL_A, r);
        rd(USC_IDX_CTL_A, r);
        bus(1'b1, USC_IDX_CTL_B, r & 8'hd9);
        rd(USC_IDX_CTL_B, r & 8'hd9);
        bus(1'b1, USC_IDX_CTL_A, 8'h80);
        bus(1'b1, USC_IDX_CTL_B, 8'h80);
        for (int i = 0; i < 2; i++) begin
            rx_frame <= '{addr: 1'b0, frame_err: 1'b0, parity_err: 1'b0, data: {1'b0, r + 8'(i)}};
            pulse(0);
        end
        check("receive_vector", 8'(receive_vector), 8'h01);
        rd(USC_IDX_STATUS, 8'ha0);
        rd(USC_IDX_RXDL, r);
        rd(USC_IDX_RXDL, r + 8'h01);
        rd(USC_IDX_STATUS, 8'h20);
        bus(1'b1, USC_IDX_CTL_B, 8'h81);
        pulse(0);
        rd(USC_IDX_STATUS, 8'h20);
        rx_frame.addr <= 1'b1;
        pulse(0);
        rd(USC_IDX_STATUS, 8'ha0);
        bus(1'b1, USC_IDX_CTL_B, 8'h00);
        check("rx_enable", 8'(rx_enable), 8'h00);
        rd(USC_IDX_STATUS, 8'h20);
        bus(1'b1, USC_IDX_CTL_A, 8'h60);
        check("empty vector", 8'(tx_empty_vector), 8'h01);
        bus(1'b1, USC_IDX_CTL_B, 8'h40);
        tx_shift_busy <= 1'b1;
        bus(1'b1, USC_IDX_TXDL, 8'ha5);
        check("empty vector", 8'(tx_empty_vector), 8'h00);
        bus(1'b1, USC_IDX_TXDL, 8'h5a);
        rd(USC_IDX_STATUS, 8'h00);
        tx_shift_busy <= 1'b0;
        for (int n = 0; n < 10 && tx_load !== 1'b1; n++) @(posedge clk);
        check("tx_data", tx_data, 8'ha5);
        for (int k = 0; k < 2; k++) begin
            pulse(1);
            check("tx done vector", 8'(tx_done_vector), 8'h01);
            if (k == 0) pulse(2);
            else bus(1'b1, USC_IDX_STATUS, 8'h40);
            rd(USC_IDX_STATUS, 8'h20);
        end
        bus(1'b1, USC_IDX_CTL_B, 8'h48);
        bus(1'b1, USC_IDX_CTL_A, 8'h09);
        tx_shift_busy <= 1'b1;
        repeat (4) @(posedge clk);
        check("txd_out", 8'(txd_out), 8'h00);
        check("txd_oe low bit", 8'(txd_oe), 8'h01);
        check("driver enable", 8'(line_driver_enable_pin), 8'h01);
        check("rx_line", 8'(rx_line), 8'h00);
        tx_bit <= 1'b1;
        repeat (4) @(posedge clk);
        check("rx_line", 8'(rx_line), 8'h01);
        check("txd_oe high bit", 8'(txd_oe), 8'h00);
        tx_shift_busy <= 1'b0;
        bus(1'b1, USC_IDX_CTL_A, 8'h04);
        bus(1'b1, USC_IDX_CTL_B, 8'h90);
        bus(1'b1, USC_IDX_STATUS, 8'h40);
        sleep_standby <= 1'b1;
        fork
            usc_remote_node_i.send_low(20);
            begin
                for (int n = 0; n < 15 && wake_req !== 1'b1; n++) @(posedge clk);
                woke = wake_req;
            end
        join
        check("wake_req seen", 8'(woke), 8'h01);
        sleep_standby <= 1'b0;
        rd(USC_IDX_STATUS, 8'h30);
        bus(1'b1, USC_IDX_STATUS, 8'h10);
        rd(USC_IDX_STATUS, 8'h20);
        bus(1'b1, USC_IDX_CTL_B, 8'h86);
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, USC_IDX_STATUS, 8'h01);
            usc_remote_node_i.send_low(4);
            repeat (8) @(posedge clk);
            sync_byte <= k ? 8'h54 : USC_SYNC_CHAR;
            sync_baud_ok <= 1'b1;
            pulse(3);
            rd(USC_IDX_STATUS, k ? 8'h28 : 8'h22);
            check("receive_vector", 8'(receive_vector), 8'(k));
            bus(1'b1, USC_IDX_STATUS, 8'h0a);
            rd(USC_IDX_STATUS, 8'h20);
        end
        end_sim();
    end
endmodule : usart_status_control_test
`default_nettype wire
